// ---- shared/rars_pkg.sv ----
package rars_pkg;
  localparam int W = 10;
  localparam int BUF_W = 11;
  localparam int AW = 8;
  localparam int CTRL_W = 4;
  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_PAT = 8'h04;
  localparam logic [AW-1:0] OFS_RLTHR = 8'h08;
  localparam logic [AW-1:0] OFS_RMPAT = 8'h0C;
  localparam logic [AW-1:0] OFS_STATUS = 8'h10;
  // control fields
  localparam int C_SLIP = 0;
  localparam int C_MAN = 1;
  localparam int C_SER = 2;
  localparam int C_RM = 3;
  localparam int C_CLR = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h8;
  // comma and skip words, bit 0 first on the line
  localparam logic [W-1:0] PAT_RST = 10'h17C;
  localparam logic [W-1:0] RMPAT_RST = 10'h0BC;
  localparam logic [5:0] RLTHR_RST = 6'h14;
  localparam logic [5:0] RL_MAX = 6'h3F;
  localparam logic [5:0] RL_ONE = 6'h01;
  // status fields
  localparam int S_SYNC = 0;
  localparam int S_PAT = 1;
  localparam int S_RLV = 2;
  localparam int S_FULL = 3;
  localparam int S_EMPTY = 4;
  localparam int S_OFF = 8;
  // word boundary
  localparam logic [3:0] OFF_LAST = 4'h9;
  localparam logic [3:0] OFF_ONE = 4'h1;
  localparam logic [3:0] OFF_ZERO = 4'h0;
  // least flag lengths in cycles
  localparam logic [1:0] HOLD_PLAIN = 2'h2;
  localparam logic [1:0] HOLD_SER = 2'h3;
  localparam logic [1:0] HOLD_ONE = 2'h1;
  localparam int ST_RLV = 0;
  localparam int ST_FULL = 1;
  localparam int ST_EMPTY = 2;
  localparam int I_SLIP = 0;
  localparam int I_POL = 1;
  localparam int I_MAN = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control code group test on a 10-bit group
  function automatic logic rars_is_k(input logic [W-1:0] c);
    logic [5:0] lo;
    logic [3:0] hi;
    lo = c[5:0];
    hi = c[9:6];
    return (lo == 6'h3C) || (lo == 6'h03) ||
           (((lo == 6'h17) || (lo == 6'h28) || (lo == 6'h1B) || (lo == 6'h24) ||
             (lo == 6'h1D) || (lo == 6'h22) || (lo == 6'h1E) || (lo == 6'h21)) &&
            ((hi == 4'h1) || (hi == 4'hE)));
  endfunction
endpackage

// ---- shared/rars_buf_if.sv ----
`timescale 1ns/10ps
interface rars_buf_if;
  import rars_pkg::*;
  logic [BUF_W-1:0] in_data;
  logic             in_valid;
  logic             in_ready;
  logic [BUF_W-1:0] out_data;
  logic             out_valid;
  logic             out_ready;
  logic             full;
  logic             empty;
  modport fill (output in_data, in_valid, out_ready,
                input  in_ready, out_data, out_valid, full, empty);
  modport store (input  in_data, in_valid, out_ready,
                 output in_ready, out_data, out_valid, full, empty);
endinterface // rars_buf_if

// ---- design/rars_buf.sv ----
`timescale 1ns/10ps
module rars_buf
  import rars_pkg::*;
(
  input logic         aclk,
  input logic         aresetn,
  rars_buf_if.store   bf
);
  typedef struct packed {
    logic [BUF_W-1:0] e0;
    logic [BUF_W-1:0] e1;
    logic             v0;
    logic             v1;
    logic             rdy;
    logic             mt;
  } rars_buf_s;

  rars_buf_s st;
  rars_buf_s next_st;

  always_comb
  begin
    next_st = st;
    if (st.v0 && bf.out_ready)
    begin
      next_st.e0 = st.e1;
      next_st.v0 = st.v1;
      next_st.v1 = 1'b0;
    end
    if (bf.in_valid && st.rdy)
    begin
      if (!next_st.v0)
      begin
        next_st.e0 = bf.in_data;
        next_st.v0 = 1'b1;
      end
      else
      begin
        next_st.e1 = bf.in_data;
        next_st.v1 = 1'b1;
      end
    end
    next_st.rdy = !next_st.v1;
    next_st.mt = !next_st.v0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.rdy <= 1'b1;
      st.mt <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign bf.out_data = st.e0;
  assign bf.out_valid = st.v0;
  assign bf.in_ready = st.rdy;
  assign bf.full = st.v1;
  assign bf.empty = st.mt;
endmodule // rars_buf

// ---- design/rars_top.sv ----
// Overview of operation
// RULE_01: A status output tells software and fabric whether word boundary lock is held.
// RULE_02: In bit-slip mode the lock status is never offered and reads low.
// RULE_03: The pattern-seen output pulses when the alignment pattern sits in the current boundary.
// RULE_04: In bit-slip mode each rising edge of the slip request moves the boundary by one bit.
// RULE_05: The fabric holds slip request and polarity invert for at least two clock cycles.
// RULE_06: The run-length alarm rises when identical consecutive bits exceed the threshold.
// RULE_07: The run-length alarm lasts two cycles, or three with the byte serializer set.
// RULE_08: While polarity invert is high every bit of the word is inverted before alignment.
// RULE_09: In manual mode the aligner relocks only while the manual enable input is high.
// RULE_10: The added flag pulses when the rate matcher inserts a skip word.
// RULE_11: The dropped flag pulses when the rate matcher removes a skip word.
// RULE_12: The full flag follows the buffer full state for at least two or three cycles.
// RULE_13: The empty flag follows the buffer empty state for at least two or three cycles.
// RULE_14: The control flag of each output word is high for a control code group.
// RULE_15: All status outputs are synchronous to the single block clock.
// RULE_16: The control flag is low for a data code group.
// RULE_17: After a slip the new boundary holds until another slip or a reset.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module rars_top
  import rars_pkg::*;
(
  input  logic            aclk,
  input  logic            aresetn,
  input  logic [W-1:0]    rx_word,
  input  logic            rx_word_valid,
  output logic            rx_word_ready,
  input  logic            slip_request,
  input  logic            polarity_invert,
  input  logic            manual_align_enable,
  output logic [W-1:0]    out_word,
  output logic            out_ctrl,
  output logic            out_valid,
  input  logic            out_ready,
  output logic            align_sync,
  output logic            align_pattern_seen,
  output logic            run_length_alarm,
  output logic            rate_match_added,
  output logic            rate_match_dropped,
  output logic            rate_match_full,
  output logic            rate_match_empty,
  input  logic [AW-1:0]   s_axi_awaddr,
  input  logic            s_axi_awvalid,
  output logic            s_axi_awready,
  input  logic [31:0]     s_axi_wdata,
  input  logic [3:0]      s_axi_wstrb,
  input  logic            s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  logic            s_axi_bready,
  input  logic [AW-1:0]   s_axi_araddr,
  input  logic            s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  logic            s_axi_rready
);
  typedef struct packed {
    logic [2:0]        s1;
    logic [2:0]        s2;
    logic              slip_q;
    logic [CTRL_W-1:0] cfg;
    logic [W-1:0]      pat;
    logic [W-1:0]      rmpat;
    logic [5:0]        thr;
    logic [W-1:0]      prev;
    logic [3:0]        off;
    logic [W-1:0]      al_word;
    logic              al_ctrl;
    logic              al_valid;
    logic              last_rm;
    logic              rl_bit;
    logic [5:0]        rl_cnt;
    logic [2:0][1:0]   hold;
    logic [2:0]        flag;
    logic              sync;
    logic              seen;
    logic              added;
    logic              dropped;
    logic              aw_got;
    logic              w_got;
    logic [AW-1:0]     awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } rars_top_s;

  rars_top_s         st;
  rars_top_s         next_st;
  rars_buf_if        bf();
  logic [W-1:0]      w_inv;
  logic [2*W-1:0]    hist;
  logic [W-1:0]      aw;
  logic [3:0]        k;
  logic [3:0]        offe;
  logic              found;
  logic              relock;
  logic              hit;
  logic              viol;
  logic              clr;
  logic              bitv;
  logic [5:0]        cnt;
  logic [1:0]        hmin;
  logic [2:0]        src;
  logic [31:0]       m;
  logic              slip_rise;
  logic              accept;
  logic              rm_hit;
  logic              drop;
  logic              ins;

  rars_buf rars_buf_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bf      (bf)
  );

  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[8*b +: 8] = d[8*b +: 8];
    return r;
  endfunction

  // async pins pass two flops before use
  assign slip_rise = st.s2[I_SLIP] && !st.slip_q; // RULE_05
  assign w_inv = rx_word ^ {W{st.s2[I_POL]}}; // RULE_08
  assign hist = {w_inv, st.prev};
  assign accept = rx_word_valid && bf.in_ready;
  assign rm_hit = (st.al_word == st.rmpat) || (st.al_word == ~st.rmpat);
  // delete a skip word only when the buffer backs up
  assign drop = st.cfg[C_RM] && st.al_valid && !bf.in_ready && rm_hit; // RULE_11
  // insert a skip word next to a skip word when the buffer runs dry
  assign ins = st.cfg[C_RM] && !st.al_valid && bf.empty && st.last_rm && bf.in_ready; // RULE_10
  assign bf.in_valid = (st.al_valid && !drop) || ins;
  assign bf.in_data = ins ? {rars_is_k(st.rmpat), st.rmpat} : {st.al_ctrl, st.al_word};
  assign bf.out_ready = out_ready;

  always_comb
  begin
    next_st = st;
    clr = 1'b0;
    m = 32'h0;
    next_st.s1 = {manual_align_enable, polarity_invert, slip_request};
    next_st.s2 = st.s1;
    next_st.slip_q = st.s2[I_SLIP];
    // register write
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (st.awaddr[AW-1:2])
        OFS_CTRL[AW-1:2]:
        begin
          m = wmerge(32'(st.cfg), st.wdata, st.wstrb);
          next_st.cfg = m[CTRL_W-1:0];
          clr = m[C_CLR];
        end
        OFS_PAT[AW-1:2]:
        begin
          m = wmerge(32'(st.pat), st.wdata, st.wstrb);
          next_st.pat = m[W-1:0];
        end
        OFS_RLTHR[AW-1:2]:
        begin
          m = wmerge(32'(st.thr), st.wdata, st.wstrb);
          next_st.thr = m[5:0];
        end
        OFS_RMPAT[AW-1:2]:
        begin
          m = wmerge(32'(st.rmpat), st.wdata, st.wstrb);
          next_st.rmpat = m[W-1:0];
        end
        OFS_STATUS[AW-1:2]: ;
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;
    // register read
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h0;
      case (s_axi_araddr[AW-1:2])
        OFS_CTRL[AW-1:2]: next_st.rdata = 32'(st.cfg);
        OFS_PAT[AW-1:2]: next_st.rdata = 32'(st.pat);
        OFS_RLTHR[AW-1:2]: next_st.rdata = 32'(st.thr);
        OFS_RMPAT[AW-1:2]: next_st.rdata = 32'(st.rmpat);
        OFS_STATUS[AW-1:2]:
        begin
          next_st.rdata[S_SYNC] = st.sync;
          next_st.rdata[S_PAT] = st.seen;
          next_st.rdata[S_RLV] = st.flag[ST_RLV];
          next_st.rdata[S_FULL] = st.flag[ST_FULL];
          next_st.rdata[S_EMPTY] = st.flag[ST_EMPTY];
          next_st.rdata[S_OFF +: 4] = st.off;
        end
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end
    next_st.arready = !next_st.rvalid;
    // pattern search over all ten boundaries, lowest wins
    found = 1'b0;
    k = OFF_ZERO;
    for (int i = W - 1; i >= 0; i--)
      if ((hist[i +: W] == st.pat) || (hist[i +: W] == ~st.pat))
      begin
        found = 1'b1;
        k = 4'(i);
      end
    relock = found && !st.cfg[C_SLIP] && (!st.cfg[C_MAN] || st.s2[I_MAN]); // RULE_09
    offe = relock ? k : st.off;
    aw = hist[offe +: W];
    hit = (aw == st.pat) || (aw == ~st.pat);
    // run length over the bits of the word in line order
    bitv = st.rl_bit;
    cnt = st.rl_cnt;
    viol = 1'b0;
    for (int i = 0; i < W; i++)
    begin
      if (w_inv[i] == bitv)
      begin
        if (cnt != RL_MAX)
          cnt = cnt + RL_ONE;
      end
      else
      begin
        bitv = w_inv[i];
        cnt = RL_ONE;
      end
      if (accept && (cnt > st.thr))
        viol = 1'b1; // RULE_06
    end
    next_st.seen = 1'b0;
    if (accept)
    begin
      next_st.prev = w_inv;
      next_st.al_word = aw;
      next_st.al_ctrl = rars_is_k(aw); // RULE_14 RULE_16
      next_st.al_valid = 1'b1;
      next_st.seen = hit; // RULE_03
      next_st.off = offe;
      next_st.rl_bit = bitv;
      next_st.rl_cnt = cnt;
    end
    else if (bf.in_ready || drop)
      next_st.al_valid = 1'b0;
    if (st.al_valid && bf.in_ready)
      next_st.last_rm = rm_hit;
    // boundary moves on a slip or a relock and otherwise holds
    if (st.cfg[C_SLIP] && slip_rise)
      next_st.off = (st.off == OFF_LAST) ? OFF_ZERO : st.off + OFF_ONE; // RULE_04 RULE_17
    // lock set wins over a software clear
    if (st.cfg[C_SLIP])
      next_st.sync = 1'b0; // RULE_02
    else if (accept && hit)
      next_st.sync = 1'b1; // RULE_01
    else if (clr)
      next_st.sync = 1'b0;
    next_st.added = ins;
    next_st.dropped = drop;
    // flag stretchers
    hmin = st.cfg[C_SER] ? HOLD_SER : HOLD_PLAIN;
    src = {bf.empty, bf.full, viol};
    for (int j = 0; j < 3; j++)
    begin
      if (src[j] && !st.flag[j])
      begin
        next_st.flag[j] = 1'b1;
        next_st.hold[j] = hmin - HOLD_ONE; // RULE_07 RULE_12 RULE_13
      end
      else if (st.hold[j] != 2'h0)
      begin
        next_st.flag[j] = 1'b1;
        next_st.hold[j] = st.hold[j] - HOLD_ONE;
      end
      else
        next_st.flag[j] = src[j];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.cfg <= CTRL_RST;
      st.pat <= PAT_RST;
      st.rmpat <= RMPAT_RST;
      st.thr <= RLTHR_RST;
    end
    else
      st <= next_st;
  end

  // every status output is a flop on the one block clock
  assign align_sync = st.sync; // RULE_15
  assign align_pattern_seen = st.seen;
  assign run_length_alarm = st.flag[ST_RLV];
  assign rate_match_full = st.flag[ST_FULL];
  assign rate_match_empty = st.flag[ST_EMPTY];
  assign rate_match_added = st.added;
  assign rate_match_dropped = st.dropped;
  assign out_word = bf.out_data[W-1:0];
  assign out_ctrl = bf.out_data[W];
  assign out_valid = bf.out_valid;
  assign rx_word_ready = bf.in_ready;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rise(f);
    !f ##1 f;
  endsequence
  sequence s_plain;
    !$past(st.cfg[C_SER]);
  endsequence
  sequence s_ser;
    $past(st.cfg[C_SER]);
  endsequence

  AST_RLV_TWO: assert property (s_rise(run_length_alarm) ##0 s_plain |-> run_length_alarm[*2]) // RULE_07
    else $error("run-length alarm shorter than two cycles");
  AST_RLV_THREE: assert property (s_rise(run_length_alarm) ##0 s_ser |-> run_length_alarm[*3]) // RULE_07
    else $error("run-length alarm shorter than three cycles");
  AST_RLV_CAUSE: assert property (viol |=> run_length_alarm) // RULE_06
    else $error("run-length violation not flagged");
  AST_FULL_MIN: assert property (s_rise(rate_match_full) ##0 s_plain |-> rate_match_full[*2]) // RULE_12
    else $error("full flag shorter than two cycles");
  AST_EMPTY_MIN: assert property (s_rise(rate_match_empty) ##0 s_ser |-> rate_match_empty[*3]) // RULE_13
    else $error("empty flag shorter than three cycles");
  AST_NO_SYNC_SLIP: assert property (st.cfg[C_SLIP] |=> !align_sync) // RULE_02
    else $error("lock status shown in bit-slip mode");
  AST_SYNC_SET: assert property (!st.cfg[C_SLIP] && accept && hit |=> align_sync) // RULE_01
    else $error("lock status not set on aligned pattern");
  AST_SLIP_STEP: assert property (st.cfg[C_SLIP] && slip_rise |=> // RULE_04
      st.off == (($past(st.off) == OFF_LAST) ? OFF_ZERO : $past(st.off) + OFF_ONE))
    else $error("slip did not move boundary by one bit");
  AST_OFF_HOLD: assert property (!slip_rise && !relock |=> $stable(st.off)) // RULE_17
    else $error("boundary moved without cause");
  AST_SEEN: assert property (accept && hit |=> align_pattern_seen ##1 // RULE_03
      (!align_pattern_seen || $past(accept && hit)))
    else $error("pattern seen not pulsed");
  AST_POL: assert property (accept |=> st.prev == $past(rx_word ^ {W{st.s2[I_POL]}})) // RULE_08
    else $error("polarity inversion wrong");
  AST_MANUAL: assert property (st.cfg[C_MAN] && !st.s2[I_MAN] && !slip_rise |=> $stable(st.off)) // RULE_09
    else $error("manual aligner relocked while disabled");
  AST_KCODE: assert property (out_valid && rars_is_k(out_word) |-> out_ctrl) // RULE_14
    else $error("control group not flagged");
  AST_DCODE: assert property (out_valid && !rars_is_k(out_word) |-> !out_ctrl) // RULE_16
    else $error("data group flagged as control");
  AST_ADD: assert property (ins |=> rate_match_added && out_valid) // RULE_10
    else $error("insertion not flagged");
  AST_DROP: assert property (drop |=> rate_match_dropped && !st.al_valid) // RULE_11
    else $error("deletion not flagged");
endmodule // rars_top

// ---- bench/rars_sink.sv ----
`timescale 1ns/10ps
module rars_sink
  import rars_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         stall,
  input  wire logic [W-1:0] out_word,
  input  wire logic         out_ctrl,
  input  wire logic         out_valid,
  output logic              out_ready,
  output logic [W-1:0]      last_word,
  output logic              last_ctrl
);
  initial
  begin
    out_ready = 1'b0;
    last_word = '0;
    last_ctrl = 1'b0;
  end
  // fabric consumer, stalls on command, keeps the last word taken
  always @(posedge aclk)
  begin
    out_ready <= !stall;
    if (out_valid && out_ready)
    begin
      last_word <= out_word;
      last_ctrl <= out_ctrl;
    end
  end
endmodule // rars_sink

// ---- bench/rars_top_test.sv ----
`timescale 1ns/10ps
module rars_top_test
  import rars_pkg::*;
;
  logic          aclk, aresetn, rx_word_valid, rx_word_ready, slip_request, polarity_invert;
  logic          manual_align_enable, out_ctrl, out_valid, out_ready, align_sync;
  logic          align_pattern_seen, run_length_alarm, rate_match_added, rate_match_dropped;
  logic          rate_match_full, rate_match_empty, stall, last_ctrl;
  logic [W-1:0]  rx_word, out_word, last_word;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, d;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp, r;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic          s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic          seen_pat, seen_add, seen_drop;
  int            errors, comparisons, rlv_run, rlv_max;
  logic [AW-1:0] ra [5] = '{OFS_CTRL, OFS_PAT, OFS_RLTHR, OFS_RMPAT, 8'h14};
  logic [31:0]   rv [5] = '{32'h8, 32'h17C, 32'h14, 32'hBC, 32'h0};

  rars_top rars_top_inst (.aclk, .aresetn, .rx_word, .rx_word_valid, .rx_word_ready,
    .slip_request, .polarity_invert, .manual_align_enable, .out_word, .out_ctrl, .out_valid,
    .out_ready, .align_sync, .align_pattern_seen, .run_length_alarm, .rate_match_added,
    .rate_match_dropped, .rate_match_full, .rate_match_empty, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rars_sink rars_sink_inst (.aclk, .stall, .out_word, .out_ctrl, .out_valid, .out_ready,
    .last_word, .last_ctrl);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = !aclk;
  end

  // sticky event flags and longest alarm run
  always @(posedge aclk)
  begin
    seen_pat <= seen_pat | align_pattern_seen;
    seen_add <= seen_add | rate_match_added;
    seen_drop <= seen_drop | rate_match_dropped;
    rlv_run <= run_length_alarm ? rlv_run + 1 : 0;
    if (rlv_run > rlv_max)
      rlv_max <= rlv_run;
  end

  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 50)
    begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, n, 0);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    tmo(n);
  endtask

  task automatic rd(input logic [AW-1:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    tmo(n);
  endtask

  // offer words back to back, each held until taken
  task automatic send(input logic [W-1:0] w, input int k);
    int n;
    repeat (k)
    begin
      rx_word <= w;
      rx_word_valid <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
        @(posedge aclk);
        if (rx_word_ready)
          break;
      end
      tmo(n);
    end
    rx_word_valid <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i]);
      chk(d, rv[i]);
      chk(r, i == 4 ? RESP_SLVERR : RESP_OKAY);
    end
    wr(OFS_RLTHR, 32'h5);
    rd(OFS_RLTHR);
    chk(d, 32'h5);
    s_axi_wstrb <= 4'h0;
    wr(OFS_RLTHR, 32'h7);
    s_axi_wstrb <= 4'hF;
    rd(OFS_RLTHR);
    chk(d, 32'h5);
    wr(8'h14, 32'h1);
    chk(r, RESP_SLVERR);
  endtask

  task automatic t_align;
    wr(OFS_CTRL, 32'h0);
    send(10'h17C, 3);
    chk(align_sync, 1'b1);
    chk(seen_pat, 1'b1);
    chk(last_ctrl, 1'b1);
    send(10'h2AA, 3);
    chk(last_word, 10'h2AA);
    chk(last_ctrl, 1'b0);
    polarity_invert <= 1'b1;
    repeat (4) @(posedge aclk);
    send(10'h2AA, 3);
    chk(last_word, 10'h155);
    polarity_invert <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic t_slip;
    logic [3:0] o;
    wr(OFS_CTRL, 32'h1);
    rd(OFS_STATUS);
    chk(d[S_SYNC], 1'b0);
    chk(align_sync, 1'b0);
    o = d[11:8];
    for (int i = 0; i < 11; i++)
    begin
      slip_request <= 1'b1;
      repeat (3) @(posedge aclk);
      slip_request <= 1'b0;
      repeat (8) @(posedge aclk);
      o = (o == OFF_LAST) ? OFF_ZERO : o + OFF_ONE;
      rd(OFS_STATUS);
      chk(d[11:8], o);
      repeat (10) @(posedge aclk);
      rd(OFS_STATUS);
      chk(d[11:8], o);
    end
    wr(OFS_CTRL, 32'h12);
    send(10'h17C, 3);
    rd(OFS_STATUS);
    chk(d[11:8], o);
    manual_align_enable <= 1'b1;
    repeat (4) @(posedge aclk);
    send(10'h17C, 3);
    chk(align_sync, 1'b1);
    manual_align_enable <= 1'b0;
  endtask

  task automatic t_rlv;
    wr(OFS_CTRL, 32'h0);
    rlv_max <= 0;
    send(10'h2AA, 4);
    chk(rlv_max, 0);
    send(10'h000, 4);
    chk(rlv_max >= 2, 1'b1);
    wr(OFS_CTRL, 32'h4);
    rlv_max <= 0;
    send(10'h3FF, 4);
    chk(rlv_max >= 3, 1'b1);
  endtask

  task automatic t_rate;
    wr(OFS_CTRL, 32'h8);
    stall <= 1'b1;
    rx_word <= RMPAT_RST;
    rx_word_valid <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(rx_word_ready, 1'b0);
    chk(rate_match_full, 1'b1);
    chk(out_valid, 1'b1);
    chk(seen_drop, 1'b1);
    rx_word_valid <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    stall <= 1'b0;
    repeat (20) @(posedge aclk);
    chk(rate_match_empty, 1'b1);
    chk(out_valid, 1'b0);
    wr(OFS_CTRL, 32'h8);
    send(RMPAT_RST, 1);
    chk(seen_add, 1'b1);
  endtask

  initial
  begin
    {aresetn, rx_word, rx_word_valid, slip_request, polarity_invert} = '0;
    {manual_align_enable, stall, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {seen_pat, seen_add, seen_drop, errors, comparisons, rlv_run, rlv_max} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_align();
    t_slip();
    t_rlv();
    t_rate();
    end_of_test();
  end
endmodule // rars_top_test
